/* hw/pccs_pkg.sv */
// constants, types and number-format helpers of the power control command block
// How it works
// RULE1: pin and operation command each gate switching
// RULE2: reset obeys pin, ignores operation command
// RULE3: pin active high, polarity programmable
// RULE4: operation command acts only when enabled
// RULE5: soft off ramps down, immediate off stops
// RULE6: on ramps to boot code, then target
// RULE7: margin selects stored high or low code
// RULE8: outputs stay low until clear and in-limit
// RULE9: temperature hot/cold warning sets status, warning
// RULE10: hot failure sets bit 7, failure low
// RULE11: every quantity checked, results in status registers
// RULE12: two masks gate warning and failure outputs
// RULE13: masked voltage sets status, leaves pin high
// RULE14: 16 bits: 5-bit exponent, 11-bit mantissa
// RULE15: exponent and mantissa are two's complement
// RULE16: format used for readings and limits
// RULE17: current equals monitor times gain plus offset
// RULE18: gain resets to one, offset to zero
// RULE19: codes 0,1 off; 2 is 1.6 V; steps down
// RULE20: host clears faults with a bare command code
package pccs_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_OPERATION   = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CFG  = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULT = 8'h03;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW  = 8'h26;
  localparam logic [7:0] CMD_GAIN        = 8'h38;
  localparam logic [7:0] CMD_OFFSET      = 8'h39;
  localparam logic [7:0] CMD_VOUT_HI_LIM = 8'h42;
  localparam logic [7:0] CMD_VOUT_LO_LIM = 8'h43;
  localparam logic [7:0] CMD_IOUT_HI_LIM = 8'h4A;
  localparam logic [7:0] CMD_HOT_FAIL    = 8'h4F;
  localparam logic [7:0] CMD_HOT_WARN    = 8'h51;
  localparam logic [7:0] CMD_COLD_WARN   = 8'h52;
  localparam logic [7:0] CMD_SUMMARY     = 8'h78;
  localparam logic [7:0] CMD_VOUT_STAT   = 8'h7A;
  localparam logic [7:0] CMD_IOUT_STAT   = 8'h7B;
  localparam logic [7:0] CMD_TEMP_STAT   = 8'h7D;
  localparam logic [7:0] CMD_WARN_STAT   = 8'h80;
  localparam logic [7:0] CMD_READ_VOUT   = 8'h8B;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_READING   = 8'h8C;
  localparam logic [7:0] CMD_READ_TEMP   = 8'h8D;
  localparam logic [7:0] CMD_WARN_MASK   = 8'hF9;
  localparam logic [7:0] CMD_FAIL_MASK   = 8'hFA;

  // ==========================================================
  // fields and reset values
  localparam int OP_ON_BIT      = 7;
  localparam int OP_SOFT_BIT    = 6;
  localparam int OP_MARGIN_HI   = 5;
  localparam int OP_MARGIN_LO   = 4;
  localparam int CFG_OP_EN_BIT  = 3;
  localparam int CFG_PIN_EN_BIT = 2;
  localparam int CFG_POL_BIT    = 1;
  localparam int CFG_PIN_IMM    = 0;
  localparam int Q_VOUT_BIT     = 7;
  localparam int Q_IOUT_BIT     = 6;
  localparam int Q_TEMP_BIT     = 5;
  localparam int T_HOT_FAIL_BIT = 7;
  localparam int T_HOT_WARN_BIT = 6;
  localparam int T_COLD_WARN_BIT = 5;
  localparam int S_HI_WARN_BIT  = 6;
  localparam int S_LO_WARN_BIT  = 5;
  localparam int SUM_OFF_BIT    = 6;
  localparam int SUM_VOUT_BIT   = 5;
  localparam int SUM_IOUT_BIT   = 4;
  localparam int SUM_TEMP_BIT   = 2;
  localparam logic [7:0]  OP_RESET      = 8'h00;
  localparam logic [7:0]  CFG_RESET     = 8'h06;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [15:0] GAIN_RESET    = 16'h0001;
  localparam logic [15:0] OFFSET_RESET  = 16'h0000;
  localparam logic [15:0] LIMIT_HI_RESET = 16'h03FF;
  localparam logic [15:0] LIMIT_LO_RESET = 16'h0400;
  localparam logic [7:0]  MARGIN_RESET  = 8'h02;

  // ==========================================================
  // voltage code decode and timing
  localparam logic [7:0]  CODE_FIRST_ON = 8'h02;
  localparam logic [7:0]  CODE_LOWEST   = 8'hFF;
  localparam logic [20:0] TOP_MICROVOLT = 21'd1600000;
  localparam logic [20:0] STEP_MICROVOLT = 21'd6250;
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_TIME_NS  = 1000;
  localparam int STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIX_FRAC      = 8;

  // ==========================================================
  // types
  typedef struct packed {
    logic        wr;
    logic [7:0]  code;
    logic [1:0]  bytes;
    logic [15:0] data;
  } pccs_cmd_t;

  typedef enum logic [1:0] {SEQ_OFF, SEQ_BOOT, SEQ_TRACK, SEQ_RAMP_DOWN} pccs_seq_t;

  // ==========================================================
  // number format helpers
  function automatic logic signed [47:0] pccs_lin_to_fix(input logic [15:0] x);
    logic signed [4:0]  n;
    logic signed [47:0] y;
    logic signed [6:0]  sh;
    n  = x[15:11]; // RULE15
    y  = 48'(signed'(x[10:0])); // RULE14
    sh = 7'(n) + 7'(FIX_FRAC);
    if (sh >= 0) begin
      return y <<< sh;
    end
    return y >>> (-sh);
  endfunction : pccs_lin_to_fix

  function automatic logic [15:0] pccs_fix_to_lin(input logic signed [47:0] v);
    logic signed [47:0] m;
    logic [15:0]        r;
    logic               found;
    r = 16'h7BFF;
    found = 1'b0;
    for (int n = -8; n < 16; n++) begin
      m = v >>> (n + FIX_FRAC);
      if (!found && m >= -48'sd1024 && m <= 48'sd1023) begin
        r = {5'(n), m[10:0]}; // RULE14
        found = 1'b1;
      end
    end
    return r;
  endfunction : pccs_fix_to_lin

endpackage : pccs_pkg

/* hw/pccs_power_control.sv */
// command, status and on/off sequencing logic of the power controller
`timescale 1ns/1ns
`default_nettype none
module pccs_power_control #(
  parameter logic [7:0] BOOT_CODE  = 8'h42,
  parameter int         STEP_CYC   = pccs_pkg::STEP_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire logic               cmdStb,
  input  wire pccs_pkg::pccs_cmd_t cmdReq,
  output var  logic               rspValid,
  output var  logic               rspKnown,
  output var  logic [15:0]        rspData,
  input  wire logic               enPin,
  input  wire logic [7:0]         voltageIdCode,
  input  wire logic [15:0]        imonVoltage,
  input  wire logic [15:0]        voutMeasured,
  input  wire logic [15:0]        tempMeasured,
  output var  logic               switchingOn,
  output var  logic               softRamping,
  output var  logic [7:0]         dacCode,
  output var  logic [20:0]        dacMicrovolts,
  output var  logic               warningOutN,
  output var  logic               failureOutN
);

  if (STEP_CYC < 1 || STEP_CYC > 65535) begin : g_chk
    $error("step cycles out of range");
  end

  // ==========================================================
  // register file
  logic [7:0]  opCtrl_q, opCtrl_d, onOffCfg_q, onOffCfg_d;
  logic [7:0]  marginHi_q, marginHi_d, marginLo_q, marginLo_d;
  logic [7:0]  warnMask_q, warnMask_d, failMask_q, failMask_d;
  logic [15:0] scale_q, scale_d, bias_q, bias_d;
  logic [15:0] hotWarn_q, hotWarn_d, coldWarn_q, coldWarn_d, hotFail_q, hotFail_d;
  logic [15:0] voutHi_q, voutHi_d, voutLo_q, voutLo_d, ioutHi_q, ioutHi_d;
  logic        wrStb;
  logic        clearFaults;

  assign wrStb = cmdStb && cmdReq.wr && cmdReq.bytes != 2'd0;
  assign clearFaults = cmdStb && cmdReq.wr && cmdReq.code == pccs_pkg::CMD_CLEAR_FAULT; // RULE20

  always_comb begin
    opCtrl_d   = opCtrl_q;
    onOffCfg_d = onOffCfg_q;
    marginHi_d = marginHi_q;
    marginLo_d = marginLo_q;
    warnMask_d = warnMask_q;
    failMask_d = failMask_q;
    scale_d    = scale_q;
    bias_d     = bias_q;
    hotWarn_d  = hotWarn_q;
    coldWarn_d = coldWarn_q;
    hotFail_d  = hotFail_q;
    voutHi_d   = voutHi_q;
    voutLo_d   = voutLo_q;
    ioutHi_d   = ioutHi_q;
    if (wrStb) begin
      case (cmdReq.code)
        pccs_pkg::CMD_OPERATION:   opCtrl_d   = cmdReq.data[7:0];
        pccs_pkg::CMD_ON_OFF_CFG:  onOffCfg_d = cmdReq.data[7:0]; // RULE3
        pccs_pkg::CMD_MARGIN_HIGH: marginHi_d = cmdReq.data[7:0];
        pccs_pkg::CMD_MARGIN_LOW:  marginLo_d = cmdReq.data[7:0];
        pccs_pkg::CMD_WARN_MASK:   warnMask_d = cmdReq.data[7:0]; // RULE12
        pccs_pkg::CMD_FAIL_MASK:   failMask_d = cmdReq.data[7:0]; // RULE12
        pccs_pkg::CMD_GAIN:        scale_d    = cmdReq.data; // RULE16
        pccs_pkg::CMD_OFFSET:      bias_d     = cmdReq.data;
        pccs_pkg::CMD_HOT_WARN:    hotWarn_d  = cmdReq.data;
        pccs_pkg::CMD_COLD_WARN:   coldWarn_d = cmdReq.data;
        pccs_pkg::CMD_HOT_FAIL:    hotFail_d  = cmdReq.data;
        pccs_pkg::CMD_VOUT_HI_LIM: voutHi_d   = cmdReq.data;
        pccs_pkg::CMD_VOUT_LO_LIM: voutLo_d   = cmdReq.data;
        pccs_pkg::CMD_IOUT_HI_LIM: ioutHi_d   = cmdReq.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      opCtrl_q   <= pccs_pkg::OP_RESET;
      onOffCfg_q <= pccs_pkg::CFG_RESET; // RULE2
      marginHi_q <= pccs_pkg::MARGIN_RESET;
      marginLo_q <= pccs_pkg::MARGIN_RESET;
      warnMask_q <= pccs_pkg::MASK_RESET;
      failMask_q <= pccs_pkg::MASK_RESET;
      scale_q    <= pccs_pkg::GAIN_RESET; // RULE18
      bias_q     <= pccs_pkg::OFFSET_RESET; // RULE18
      hotWarn_q  <= pccs_pkg::LIMIT_HI_RESET;
      coldWarn_q <= pccs_pkg::LIMIT_LO_RESET;
      hotFail_q  <= pccs_pkg::LIMIT_HI_RESET;
      voutHi_q   <= pccs_pkg::LIMIT_HI_RESET;
      voutLo_q   <= pccs_pkg::LIMIT_LO_RESET;
      ioutHi_q   <= pccs_pkg::LIMIT_HI_RESET;
    end else begin
      opCtrl_q   <= opCtrl_d;
      onOffCfg_q <= onOffCfg_d;
      marginHi_q <= marginHi_d;
      marginLo_q <= marginLo_d;
      warnMask_q <= warnMask_d;
      failMask_q <= failMask_d;
      scale_q    <= scale_d;
      bias_q     <= bias_d;
      hotWarn_q  <= hotWarn_d;
      coldWarn_q <= coldWarn_d;
      hotFail_q  <= hotFail_d;
      voutHi_q   <= voutHi_d;
      voutLo_q   <= voutLo_d;
      ioutHi_q   <= ioutHi_d;
    end
  end

  // ==========================================================
  // readings, comparisons and sticky status
  logic signed [47:0] imonFix, prodFix, tempFix, voutFix, ioutFix;
  logic signed [95:0] prodWide;
  logic [15:0] ioutRead_q, ioutRead_d, tempRead_q, tempRead_d, voutRead_q, voutRead_d;
  logic [7:0]  tempStat_q, tempStat_d, voutStat_q, voutStat_d, ioutStat_q, ioutStat_d;
  logic [7:0]  warnCause, failCause, summary;
  logic        hotW, coldW, hotF, voutHiW, voutLoW, ioutHiW;
  logic        warnN_q, warnN_d, failN_q, failN_d;

  always_comb begin
    imonFix  = pccs_pkg::pccs_lin_to_fix(imonVoltage); // RULE16
    prodWide = imonFix * pccs_pkg::pccs_lin_to_fix(scale_q);
    prodFix  = 48'(prodWide >>> pccs_pkg::FIX_FRAC);
    ioutFix  = prodFix + pccs_pkg::pccs_lin_to_fix(bias_q); // RULE17
    ioutRead_d = pccs_pkg::pccs_fix_to_lin(ioutFix); // RULE17
    tempRead_d = tempMeasured;
    voutRead_d = voutMeasured;
    tempFix  = pccs_pkg::pccs_lin_to_fix(tempMeasured);
    voutFix  = pccs_pkg::pccs_lin_to_fix(voutMeasured);
    hotW     = tempFix > pccs_pkg::pccs_lin_to_fix(hotWarn_q); // RULE9
    coldW    = tempFix < pccs_pkg::pccs_lin_to_fix(coldWarn_q); // RULE9
    hotF     = tempFix > pccs_pkg::pccs_lin_to_fix(hotFail_q); // RULE10
    voutHiW  = voutFix > pccs_pkg::pccs_lin_to_fix(voutHi_q); // RULE11
    voutLoW  = voutFix < pccs_pkg::pccs_lin_to_fix(voutLo_q); // RULE11
    ioutHiW  = pccs_pkg::pccs_lin_to_fix(ioutRead_q) > pccs_pkg::pccs_lin_to_fix(ioutHi_q); // RULE11
    // set wins over clear; clear only drops bits whose condition is gone
    tempStat_d = clearFaults ? 8'h00 : tempStat_q; // RULE8
    voutStat_d = clearFaults ? 8'h00 : voutStat_q;
    ioutStat_d = clearFaults ? 8'h00 : ioutStat_q;
    tempStat_d[pccs_pkg::T_HOT_WARN_BIT]  = tempStat_d[pccs_pkg::T_HOT_WARN_BIT] | hotW; // RULE9
    tempStat_d[pccs_pkg::T_COLD_WARN_BIT] = tempStat_d[pccs_pkg::T_COLD_WARN_BIT] | coldW; // RULE9
    tempStat_d[pccs_pkg::T_HOT_FAIL_BIT]  = tempStat_d[pccs_pkg::T_HOT_FAIL_BIT] | hotF; // RULE10
    voutStat_d[pccs_pkg::S_HI_WARN_BIT] = voutStat_d[pccs_pkg::S_HI_WARN_BIT] | voutHiW; // RULE11
    voutStat_d[pccs_pkg::S_LO_WARN_BIT] = voutStat_d[pccs_pkg::S_LO_WARN_BIT] | voutLoW; // RULE11
    ioutStat_d[pccs_pkg::S_HI_WARN_BIT] = ioutStat_d[pccs_pkg::S_HI_WARN_BIT] | ioutHiW; // RULE11
    warnCause = 8'h00;
    warnCause[pccs_pkg::Q_VOUT_BIT] = |voutStat_q; // RULE13
    warnCause[pccs_pkg::Q_IOUT_BIT] = |ioutStat_q;
    warnCause[pccs_pkg::Q_TEMP_BIT] = tempStat_q[pccs_pkg::T_HOT_WARN_BIT]
                                    | tempStat_q[pccs_pkg::T_COLD_WARN_BIT];
    failCause = 8'h00;
    failCause[pccs_pkg::Q_TEMP_BIT] = tempStat_q[pccs_pkg::T_HOT_FAIL_BIT];
    warnN_d = ~|(warnCause & ~warnMask_q); // RULE8 RULE12 RULE13
    failN_d = ~|(failCause & ~failMask_q); // RULE8 RULE10 RULE12
    summary = 8'h00;
    summary[pccs_pkg::SUM_OFF_BIT]  = ~switchingOn;
    summary[pccs_pkg::SUM_VOUT_BIT] = |voutStat_q;
    summary[pccs_pkg::SUM_IOUT_BIT] = |ioutStat_q;
    summary[pccs_pkg::SUM_TEMP_BIT] = |tempStat_q;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ioutRead_q <= 16'h0000;
      tempRead_q <= 16'h0000;
      voutRead_q <= 16'h0000;
      tempStat_q <= 8'h00;
      voutStat_q <= 8'h00;
      ioutStat_q <= 8'h00;
      warnN_q    <= 1'b1;
      failN_q    <= 1'b1;
    end else begin
      ioutRead_q <= ioutRead_d;
      tempRead_q <= tempRead_d;
      voutRead_q <= voutRead_d;
      tempStat_q <= tempStat_d;
      voutStat_q <= voutStat_d;
      ioutStat_q <= ioutStat_d;
      warnN_q    <= warnN_d;
      failN_q    <= failN_d;
    end
  end

  assign warningOutN = warnN_q;
  assign failureOutN = failN_q;

  // ==========================================================
  // read answers
  logic        rspValid_q, rspValid_d, rspKnown_q, rspKnown_d;
  logic [15:0] rspData_q, rspData_d;

  always_comb begin
    rspValid_d = cmdStb && !cmdReq.wr;
    rspKnown_d = 1'b1;
    rspData_d  = 16'h0000;
    case (cmdReq.code)
      pccs_pkg::CMD_OPERATION:   rspData_d = {8'h00, opCtrl_q};
      pccs_pkg::CMD_ON_OFF_CFG:  rspData_d = {8'h00, onOffCfg_q};
      pccs_pkg::CMD_MARGIN_HIGH: rspData_d = {8'h00, marginHi_q};
      pccs_pkg::CMD_MARGIN_LOW:  rspData_d = {8'h00, marginLo_q};
      pccs_pkg::CMD_WARN_MASK:   rspData_d = {8'h00, warnMask_q};
      pccs_pkg::CMD_FAIL_MASK:   rspData_d = {8'h00, failMask_q};
      pccs_pkg::CMD_GAIN:        rspData_d = scale_q;
      pccs_pkg::CMD_OFFSET:      rspData_d = bias_q;
      pccs_pkg::CMD_HOT_WARN:    rspData_d = hotWarn_q;
      pccs_pkg::CMD_COLD_WARN:   rspData_d = coldWarn_q;
      pccs_pkg::CMD_HOT_FAIL:    rspData_d = hotFail_q;
      pccs_pkg::CMD_VOUT_HI_LIM: rspData_d = voutHi_q;
      pccs_pkg::CMD_VOUT_LO_LIM: rspData_d = voutLo_q;
      pccs_pkg::CMD_IOUT_HI_LIM: rspData_d = ioutHi_q;
      pccs_pkg::CMD_SUMMARY:     rspData_d = {8'h00, summary}; // RULE11
      pccs_pkg::CMD_VOUT_STAT:   rspData_d = {8'h00, voutStat_q};
      pccs_pkg::CMD_IOUT_STAT:   rspData_d = {8'h00, ioutStat_q};
      pccs_pkg::CMD_TEMP_STAT:   rspData_d = {8'h00, tempStat_q};
      pccs_pkg::CMD_WARN_STAT:   rspData_d = {8'h00, warnCause};
      pccs_pkg::CMD_READ_VOUT:   rspData_d = voutRead_q;
      pccs_pkg::CMD_OUTPUT_CURRENT_READING:   rspData_d = ioutRead_q;
      pccs_pkg::CMD_READ_TEMP:   rspData_d = tempRead_q;
      default:                   rspKnown_d = 1'b0;
    endcase
    if (!rspValid_d) begin
      rspData_d  = 16'h0000;
      rspKnown_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rspValid_q <= 1'b0;
      rspKnown_q <= 1'b0;
      rspData_q  <= 16'h0000;
    end else begin
      rspValid_q <= rspValid_d;
      rspKnown_q <= rspKnown_d;
      rspData_q  <= rspData_d;
    end
  end

  assign rspValid = rspValid_q;
  assign rspKnown = rspKnown_q;
  assign rspData  = rspData_q;

  // ==========================================================
  // on/off decision and soft ramp sequencer
  pccs_pkg::pccs_seq_t seq_q, seq_d;
  logic [7:0]  dac_q, dac_d, dest;
  logic [15:0] tick_q, tick_d;
  logic [20:0] uv_q, uv_d;
  logic        pinOn, opOn, runReq, softOff, stepNow, destOff, marginSel;

  always_comb begin
    pinOn = !onOffCfg_q[pccs_pkg::CFG_PIN_EN_BIT]
          || (enPin == onOffCfg_q[pccs_pkg::CFG_POL_BIT]); // RULE1 RULE3
    opOn  = !onOffCfg_q[pccs_pkg::CFG_OP_EN_BIT] || opCtrl_q[pccs_pkg::OP_ON_BIT]; // RULE1 RULE4
    marginSel = onOffCfg_q[pccs_pkg::CFG_OP_EN_BIT]
              && (opCtrl_q[pccs_pkg::OP_MARGIN_HI] || opCtrl_q[pccs_pkg::OP_MARGIN_LO]);
    if (marginSel && opCtrl_q[pccs_pkg::OP_MARGIN_HI]) begin
      dest = marginHi_q; // RULE7
    end else if (marginSel) begin
      dest = marginLo_q; // RULE7
    end else begin
      dest = voltageIdCode;
    end
    destOff = dest < pccs_pkg::CODE_FIRST_ON; // RULE19
    runReq  = pinOn && opOn && !destOff;
    softOff = opOn ? !onOffCfg_q[pccs_pkg::CFG_PIN_IMM]
                   : opCtrl_q[pccs_pkg::OP_SOFT_BIT]; // RULE5
    stepNow = tick_q == 16'(STEP_CYC - 1);
    tick_d  = (stepNow || seq_q == pccs_pkg::SEQ_OFF) ? 16'h0000 : tick_q + 16'h0001;
    seq_d = seq_q;
    dac_d = dac_q;
    case (seq_q)
      pccs_pkg::SEQ_OFF: begin
        dac_d = 8'h00;
        if (runReq) begin
          seq_d = pccs_pkg::SEQ_BOOT; // RULE6
          dac_d = pccs_pkg::CODE_LOWEST;
        end
      end
      pccs_pkg::SEQ_BOOT: begin
        if (stepNow && dac_q > BOOT_CODE) begin
          dac_d = dac_q - 8'h01; // RULE6
        end else if (stepNow && dac_q < BOOT_CODE) begin
          dac_d = dac_q + 8'h01;
        end else if (dac_q == BOOT_CODE) begin
          seq_d = pccs_pkg::SEQ_TRACK; // RULE6
        end
      end
      pccs_pkg::SEQ_TRACK: begin
        if (stepNow && dac_q > dest) begin
          dac_d = dac_q - 8'h01;
        end else if (stepNow && dac_q < dest) begin
          dac_d = dac_q + 8'h01;
        end
      end
      pccs_pkg::SEQ_RAMP_DOWN: begin
        if (runReq) begin
          seq_d = pccs_pkg::SEQ_TRACK;
        end else if (dac_q == pccs_pkg::CODE_LOWEST) begin
          seq_d = pccs_pkg::SEQ_OFF;
          dac_d = 8'h00;
        end else if (stepNow) begin
          dac_d = dac_q + 8'h01; // RULE5
        end
      end
      default: begin
        seq_d = pccs_pkg::SEQ_OFF;
        dac_d = 8'h00;
      end
    endcase
    if (!runReq && (seq_q == pccs_pkg::SEQ_BOOT || seq_q == pccs_pkg::SEQ_TRACK)) begin
      seq_d = softOff ? pccs_pkg::SEQ_RAMP_DOWN : pccs_pkg::SEQ_OFF; // RULE5
      dac_d = softOff ? dac_q : 8'h00; // RULE5
    end
    if (dac_d < pccs_pkg::CODE_FIRST_ON) begin
      uv_d = 21'd0; // RULE19
    end else begin
      uv_d = pccs_pkg::TOP_MICROVOLT
           - 21'(21'(dac_d - pccs_pkg::CODE_FIRST_ON) * pccs_pkg::STEP_MICROVOLT); // RULE19
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_q  <= pccs_pkg::SEQ_OFF;
      dac_q  <= 8'h00;
      tick_q <= 16'h0000;
      uv_q   <= 21'd0;
    end else begin
      seq_q  <= seq_d;
      dac_q  <= dac_d;
      tick_q <= tick_d;
      uv_q   <= uv_d;
    end
  end

  assign switchingOn   = seq_q != pccs_pkg::SEQ_OFF;
  assign softRamping   = seq_q == pccs_pkg::SEQ_BOOT || seq_q == pccs_pkg::SEQ_RAMP_DOWN;
  assign dacCode       = dac_q;
  assign dacMicrovolts = uv_q;

endmodule : pccs_power_control
`default_nettype wire

/* testbench/pccs_host_model.sv */
// host side model that issues finished serial commands to the block
`timescale 1ns/1ns
`default_nettype none
module pccs_host_model (
  input  wire logic                sys_clk,
  output var  logic                cmdStb,
  output var  pccs_pkg::pccs_cmd_t cmdReq
);
  initial begin
    cmdStb = 1'b0;
    cmdReq = '0;
  end
  // ==========================================================
  // one command per call, request held for one taking edge
  task automatic cmd(input logic w, input logic [7:0] c, input logic [1:0] n,
                     input logic [15:0] d);
    @(posedge sys_clk);
    cmdStb <= 1'b1;
    cmdReq <= '{wr: w, code: c, bytes: n, data: d};
    @(posedge sys_clk);
    cmdStb <= 1'b0;
    cmdReq <= '0;
  endtask : cmd
  task automatic clear();
    cmd(1'b1, pccs_pkg::CMD_CLEAR_FAULT, 2'd0, 16'h0000);
  endtask : clear
endmodule : pccs_host_model
`default_nettype wire

/* testbench/pccs_properties.sv */
// concurrent checks on the ports of the power control block
`timescale 1ns/1ns
`default_nettype none
module pccs_properties (
  input wire logic                sys_clk,
  input wire logic                arst_n,
  input wire logic                cmdStb,
  input wire pccs_pkg::pccs_cmd_t cmdReq,
  input wire logic                rspValid,
  input wire logic                rspKnown,
  input wire logic [15:0]         rspData,
  input wire logic                enPin,
  input wire logic [7:0]          voltageIdCode,
  input wire logic [15:0]         imonVoltage,
  input wire logic [15:0]         voutMeasured,
  input wire logic [15:0]         tempMeasured,
  input wire logic                switchingOn,
  input wire logic                softRamping,
  input wire logic [7:0]          dacCode,
  input wire logic [20:0]         dacMicrovolts,
  input wire logic                warningOutN,
  input wire logic                failureOutN
);
  logic rdReq, wRel, fRel;
  assign rdReq = cmdStb & ~cmdReq.wr;
  assign wRel = cmdStb & cmdReq.wr &
                (cmdReq.code inside {pccs_pkg::CMD_CLEAR_FAULT, pccs_pkg::CMD_WARN_MASK});
  assign fRel = cmdStb & cmdReq.wr &
                (cmdReq.code inside {pccs_pkg::CMD_CLEAR_FAULT, pccs_pkg::CMD_FAIL_MASK});
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // properties
  property p_rsp; rdReq |=> rspValid; endproperty
  a_rsp: assert property (p_rsp) else $error("read not answered");
  property p_unknown; rspValid && !rspKnown |-> rspData == 16'h0000; endproperty
  a_unknown: assert property (p_unknown) else $error("refused read data");
  property p_off; !switchingOn |-> dacCode == 8'h00; endproperty
  a_off: assert property (p_off) else $error("code while off");
  property p_boot; $rose(switchingOn) |-> softRamping && dacCode == 8'hFF; endproperty
  a_boot: assert property (p_boot) else $error("start not soft");
  property p_step;
    softRamping && $past(softRamping) && $changed(dacCode) |->
      dacCode == $past(dacCode) + 8'h01 || dacCode == $past(dacCode) - 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("ramp step wrong");
  property p_decode;
    $stable(dacCode) |-> dacMicrovolts == ((dacCode < 8'h02) ? 21'd0 :
      21'd1600000 - 21'(dacCode - 8'h02) * 21'd6250);
  endproperty
  a_decode: assert property (p_decode) else $error("code decode wrong");
  property p_warn_rel; $rose(warningOutN) |-> $past(wRel, 2); endproperty
  a_warn_rel: assert property (p_warn_rel) else $error("warning released");
  property p_fail_rel; $rose(failureOutN) |-> $past(fRel, 2); endproperty
  a_fail_rel: assert property (p_fail_rel) else $error("failure released");
  c_on: cover property ($rose(switchingOn));
  c_warn: cover property ($fell(warningOutN));
  c_fail: cover property ($fell(failureOutN));
endmodule : pccs_properties
bind pccs_power_control pccs_properties u_props (.*);
`default_nettype wire

/* testbench/pccs_power_control_bench.sv */
// self-checking bench of the power control block
`timescale 1ns/1ns
`default_nettype none
module pccs_power_control_bench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic enPin = 1'b0;
  logic [7:0] voltageIdCode = 8'h00;
  logic [15:0] imonVoltage = 16'h0000;
  logic [15:0] voutMeasured = 16'h0000;
  logic [15:0] tempMeasured = 16'h0019;
  logic cmdStb, rspValid, rspKnown, switchingOn, softRamping, warningOutN, failureOutN;
  pccs_pkg::pccs_cmd_t cmdReq;
  logic [15:0] rspData;
  logic [7:0] dacCode, vcode;
  logic [20:0] dacMicrovolts;
  logic [16:0] expQ[$];
  int num_errors = 0, compares = 0, cycles = 0;
  logic [31:0] seed = 32'h0bb63119;
  logic [7:0] rc[12] = '{8'h02, 8'h01, 8'hF9, 8'hFA, 8'h25, 8'h38, 8'h39, 8'h51, 8'h52,
                         8'h7D, 8'h78, 8'hEE};
  logic [16:0] re[12] = '{17'h10006, 17'h10000, 17'h10000, 17'h10000, 17'h10002, 17'h10001,
                          17'h10000, 17'h103FF, 17'h10400, 17'h10000, 17'h10040, 17'h00000};
  always #50 sys_clk = ~sys_clk;
  pccs_power_control #(.BOOT_CODE(8'h08), .STEP_CYC(1)) u_dut (.*);
  pccs_host_model u_host (.sys_clk(sys_clk), .cmdStb(cmdStb), .cmdReq(cmdReq));
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic signed [47:0] fix(input logic [15:0] x);
    return 48'(signed'(x[10:0])) <<< (int'(signed'(x[15:11])) + 8);
  endfunction : fix
  function automatic logic [15:0] enc(input logic signed [47:0] v);
    logic signed [47:0] m;
    for (int n = -8; n < 16; n++) begin
      m = v >>> (n + 8);
      if (m >= -1024 && m <= 1023) return {5'(n), m[10:0]};
    end
    return 16'h7BFF;
  endfunction : enc
  task automatic wr(input logic [7:0] c, input logic [1:0] n, input logic [15:0] d);
    u_host.cmd(1'b1, c, n, d);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [16:0] e);
    expQ.push_back(e);
    u_host.cmd(1'b0, c, 2'd0, 16'h0000);
  endtask : rd
  task automatic settle(input logic [7:0] c);
    for (int i = 0; i < 3000 && !(dacCode === c && softRamping === 1'b0); i++) begin
      @(posedge sys_clk);
    end
  endtask : settle
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      results();
    end
    if (rspValid === 1'b1) begin
      check({rspKnown, rspData}, (expQ.size() > 0) ? 32'(expQ.pop_front()) : 32'h1);
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    tick(4);
    arst_n <= 1'b1;
    wr(8'h7D, 2'd1, 16'h00FF);
    for (int i = 0; i < 12; i++) rd(rc[i], re[i]);
    seed = lfsr(seed);
    imonVoltage <= {6'h00, seed[9:0]};
    tick(3);
    rd(8'h8C, {1'b1, enc(fix({6'h00, seed[9:0]}))});
    wr(8'h38, 2'd2, 16'h0002);
    wr(8'h39, 2'd2, 16'h0001);
    imonVoltage <= 16'hFFFE;
    tick(3);
    rd(8'h8C, {1'b1, enc(((fix(16'hFFFE) * fix(16'h0002)) >>> 8) + fix(16'h0001))});
    wr(8'h51, 2'd2, 16'h0032);
    wr(8'h4F, 2'd2, 16'h0046);
    wr(8'h52, 2'd2, 16'h000A);
    tempMeasured <= 16'h003C;
    tick(4);
    check({warningOutN, failureOutN}, 2'b01);
    rd(8'h7D, 17'h10040);
    u_host.clear();
    tick(4);
    check(warningOutN, 1'b0);
    tempMeasured <= 16'h0050;
    tick(4);
    check({warningOutN, failureOutN}, 2'b00);
    tempMeasured <= 16'h0005;
    tick(4);
    rd(8'h7D, 17'h100E0);
    tempMeasured <= 16'h0019;
    tick(2);
    u_host.clear();
    tick(4);
    check({warningOutN, failureOutN}, 2'b11);
    rd(8'h7D, 17'h10000);
    wr(8'hF9, 2'd1, 16'h0080);
    wr(8'hFA, 2'd1, 16'h0020);
    wr(8'h42, 2'd2, 16'h0001);
    voutMeasured <= 16'h0005;
    tempMeasured <= 16'h0050;
    tick(4);
    check(failureOutN, 1'b1);
    rd(8'h7A, 17'h10040);
    rd(8'h80, 17'h100A0);
    voutMeasured <= 16'h0000;
    tempMeasured <= 16'h0019;
    tick(2);
    u_host.clear();
    tick(4);
    check(warningOutN, 1'b1);
    seed = lfsr(seed);
    vcode = 8'h02 + {2'b00, seed[5:0]};
    voltageIdCode <= vcode;
    enPin <= 1'b1;
    wr(8'h01, 2'd1, 16'h0000);
    settle(vcode);
    check({switchingOn, dacCode}, {1'b1, vcode});
    check(dacMicrovolts, 32'(21'd1600000 - 21'(vcode - 8'h02) * 21'd6250));
    wr(8'h02, 2'd1, 16'h0004);
    settle(8'h00);
    check({switchingOn, dacCode}, 9'h000);
    wr(8'h25, 2'd1, 16'h0020);
    wr(8'h26, 2'd1, 16'h0030);
    wr(8'h02, 2'd1, 16'h0008);
    wr(8'h01, 2'd1, 16'h00A0);
    settle(8'h20);
    check(dacCode, 8'h20);
    wr(8'h01, 2'd1, 16'h0090);
    settle(8'h30);
    check(dacCode, 8'h30);
    wr(8'h01, 2'd1, 16'h0000);
    tick(2);
    check({switchingOn, dacCode}, 9'h000);
    results();
  end
endmodule : pccs_power_control_bench
`default_nettype wire
